// File: rtl/servo_pkg.sv
package servo_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ       = 50000;
  localparam int MAX_RATE_KPPS = 200;
  // Shortest legal spacing of command pulses, rounded up to whole cycles.
  localparam int MIN_GAP_CYC   = (CLK_KHZ + MAX_RATE_KPPS - 1) / MAX_RATE_KPPS;
  localparam int GAP_W         = 9;
  localparam logic [GAP_W-1:0] MIN_GAP = GAP_W'(MIN_GAP_CYC);

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] FUNC_SETUP_OFF  = 8'h00;
  localparam logic [7:0] PULSE_SETUP_OFF = 8'h04;
  localparam logic [7:0] INPUT_FUNC_OFF  = 8'h08;
  localparam logic [7:0] LOCK_SPEED_OFF  = 8'h0C;
  localparam logic [7:0] ERR_COUNT_OFF   = 8'h10;
  localparam logic [7:0] STATUS_OFF      = 8'h14;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] FUNC_SETUP_RST  = 16'h0000;
  localparam logic [15:0] PULSE_SETUP_RST = 16'h0000;
  localparam logic [3:0]  INPUT_FUNC_RST  = 4'h0;
  localparam logic [15:0] LOCK_SPEED_RST  = 16'h0010;

  // ==========================================================================
  // Field positions
  localparam int RUN_AUTO_BIT   = 0;
  localparam int FWD_IGNORE_BIT = 2;
  localparam int FMT_LSB        = 3;
  localparam int FMT_MSB        = 5;
  localparam int CLR_EDGE_BIT   = 10;
  localparam int ST_ENABLE      = 0;
  localparam int ST_GAIN        = 1;
  localparam int ST_ALT         = 2;
  localparam int ST_LOCK        = 3;
  localparam int ST_INHIBIT     = 4;
  localparam int ST_REVERSE     = 5;
  localparam int ST_FWD_INH     = 6;
  localparam int ST_OVERRATE    = 7;

  // ==========================================================================
  // Input function codes
  localparam logic [3:0] IFN_GAIN_LAST       = 4'h1;
  localparam logic [3:0] IFN_SPEED_FIRST     = 4'h3;
  localparam logic [3:0] IFN_SPEED_GAIN_LAST = 4'h5;
  localparam logic [3:0] IFN_SPEED_LAST      = 4'h6;
  localparam logic [3:0] IFN_MODE_FIRST      = 4'h7;
  localparam logic [3:0] IFN_MODE_LAST       = 4'h9;
  localparam logic [3:0] IFN_LOCK            = 4'hA;
  localparam logic [3:0] IFN_INHIBIT         = 4'hB;

  typedef enum logic [2:0] {
    FMT_PULSE_DIR = 3'h0,
    FMT_TRAINS    = 3'h1,
    FMT_QUAD      = 3'h2
  } pulse_fmt_t;

endpackage

// File: rtl/rise_detect.sv
`timescale 1ns/1ps
module rise_detect #(
  parameter int WIDTH = 1
) (
  input  logic             clk_i,
  input  logic             rst_i,
  input  logic             ce_i,
  input  logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  always_comb begin
    next_prev = level_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else if (ce_i) begin
      prev <= next_prev;
    end
  end

  assign rise_o = level_i & ~prev;

endmodule // rise_detect

// File: rtl/pulse_decoder.sv
`timescale 1ns/1ps
module pulse_decoder
  import servo_pkg::*;
(
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       ce_i,
  input  pulse_fmt_t format_i,
  input  logic       a_i,
  input  logic       b_i,
  output logic       step_o,
  output logic       reverse_o
);

  logic a_q;
  logic b_q;
  logic next_step;
  logic next_rev;
  logic a_rise;
  logic b_rise;

  assign a_rise = a_i & ~a_q;
  assign b_rise = b_i & ~b_q;

  always_comb begin
    next_step = 1'b0;
    next_rev  = reverse_o;
    case (format_i)
      FMT_TRAINS: begin
        // Coincident edges on both trains cancel rather than guess a direction.
        if (a_rise && !b_rise) begin // see RQ1
          next_step = 1'b1;
          next_rev  = 1'b1;
        end else if (b_rise && !a_rise) begin
          next_step = 1'b1;
          next_rev  = 1'b0;
        end
      end
      FMT_QUAD: begin
        // A double change is a lost phase; it is dropped, not counted.
        if ((a_i ^ a_q) ^ (b_i ^ b_q)) begin // see RQ1
          next_step = 1'b1;
          next_rev  = ~(a_i ^ b_q);
        end
      end
      default: begin
        if (a_rise) begin // see RQ1
          next_step = 1'b1;
          next_rev  = b_i;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q       <= 1'b0;
      b_q       <= 1'b0;
      step_o    <= 1'b0;
      reverse_o <= 1'b0;
    end else if (ce_i) begin
      a_q       <= a_i;
      b_q       <= b_i;
      step_o    <= next_step;
      reverse_o <= next_rev;
    end
  end

  pulse_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    ce_i && format_i == FMT_PULSE_DIR && a_i && !a_q
    |=> step_o && reverse_o == $past(b_i))
    else $error("pulse and sign step not decoded");

  quad_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    ce_i && format_i == FMT_QUAD && (a_i != a_q) && (b_i == b_q)
    |=> step_o && reverse_o == $past(!(a_i ^ b_q)))
    else $error("quadrature edge not decoded");

endmodule // pulse_decoder

// File: rtl/servo_command_input_decoder.sv
`timescale 1ns/1ps
// Behaviour
// RQ1: Command pulses are decoded as pulse plus sign, two pulse trains or quadrature per setup bits.
// RQ2: Pulses up to the maximum rate are taken, and a faster host is flagged.
// RQ3: An active error counter clear forces the position error counter to zero.
// RQ4: A pulse setup bit makes the clear act on a high level or only on a rising edge.
// RQ5: With auto run off, the servo is enabled only while the run input is on.
// RQ6: With auto run on, the run input is ignored and the servo stays enabled.
// RQ7: The multifunction input cuts the speed loop gain for functions 0, 1, or 3 to 5 with no speed chosen.
// RQ8: For functions 7 to 9 the multifunction input selects the alternate control mode.
// RQ9: For function 10 the multifunction input locks position while speed is within the lock setting.
// RQ10: For function 11 the multifunction input blocks all command pulses and stops the motor.
// RQ11: For functions 3 to 6 with a speed chosen, the multifunction input gives reverse when on.
// RQ12: The forward prohibit input inhibits forward rotation while it is off.
// RQ13: A function setup bit makes the forward prohibit input ignored.
// RQ14: For functions 3 to 6 the two speed select inputs choose an internal speed.
// RQ15: The error counter adds signed command steps and subtracts signed feedback steps.
module servo_command_input_decoder
  import servo_pkg::*;
#(
  parameter int ERR_W = 24
) (
  input  logic             clk_i,
  input  logic             rst_i,
  input  logic             ce_i,
  input  logic             wb_cyc_i,
  input  logic             wb_stb_i,
  input  logic             wb_we_i,
  input  logic [7:0]       wb_adr_i,
  input  logic [3:0]       wb_sel_i,
  input  logic [31:0]      wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  logic             pulse_a_i,
  input  logic             pulse_b_i,
  input  logic             error_counter_clear_input_i,
  input  logic             run_command_i,
  input  logic             multifunction_input_i,
  input  logic             forward_prohibit_input_i,
  input  logic             speed_select_one_i,
  input  logic             speed_select_two_i,
  input  logic [15:0]      motor_speed_i,
  input  logic             feedback_step_i,
  input  logic             feedback_reverse_i,
  output logic             servo_enable_o,
  output logic             gain_reduce_o,
  output logic             alt_mode_o,
  output logic             position_lock_o,
  output logic             pulse_inhibit_o,
  output logic [1:0]       internal_speed_o,
  output logic             internal_reverse_o,
  output logic             forward_inhibit_o,
  output logic [ERR_W-1:0] error_count_o
);

  // ==========================================================================
  // Configuration and decode
  logic [15:0] func_setup;
  logic [15:0] pulse_setup;
  logic [3:0]  input_func;
  logic [15:0] lock_speed;
  logic        overrate;
  logic [15:0] next_func_setup;
  logic [15:0] next_pulse_setup;
  logic [3:0]  next_input_func;
  logic [15:0] next_lock_speed;
  logic        next_overrate;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        run_auto;
  logic        fwd_ignore;
  logic        clr_edge_mode;
  logic        speed_mode;
  logic        speed_chosen;
  logic        cmd_step;
  logic        cmd_rev;
  logic        clr_rise;
  logic        clear_now;
  logic        overrate_hit;
  logic        bus_req;
  logic        bus_wr;
  logic [7:0]  adr_word;
  logic [7:0]  status;

  assign run_auto      = func_setup[RUN_AUTO_BIT];
  assign fwd_ignore    = func_setup[FWD_IGNORE_BIT];
  assign clr_edge_mode = pulse_setup[CLR_EDGE_BIT];
  assign speed_mode    = (input_func >= IFN_SPEED_FIRST) && (input_func <= IFN_SPEED_LAST);
  assign speed_chosen  = speed_select_one_i | speed_select_two_i;
  assign bus_req       = wb_cyc_i & wb_stb_i;
  assign bus_wr        = bus_req & wb_we_i & wb_ack_o;
  assign adr_word      = {wb_adr_i[7:2], 2'b00};

  assign status = {overrate, forward_inhibit_o, internal_reverse_o, pulse_inhibit_o,
                   position_lock_o, alt_mode_o, gain_reduce_o, servo_enable_o};

  pulse_decoder u_decoder (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .format_i  (pulse_fmt_t'(pulse_setup[FMT_MSB:FMT_LSB])),
    .a_i       (pulse_a_i),
    .b_i       (pulse_b_i),
    .step_o    (cmd_step),
    .reverse_o (cmd_rev)
  );

  rise_detect #(
    .WIDTH (1)
  ) u_clear_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .level_i (error_counter_clear_input_i),
    .rise_o  (clr_rise)
  );

  // The edge mode lets a host leave the clear input asserted without
  // freezing the loop; only the level mode holds the counter at zero.
  assign clear_now = clr_edge_mode ? clr_rise : error_counter_clear_input_i; // see RQ4

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? dat[15:8] : old_v[15:8], sel[0] ? dat[7:0] : old_v[7:0]};
  endfunction

  // ==========================================================================
  // Register bus
  always_comb begin
    next_ack         = bus_req & ~wb_ack_o;
    next_dat         = 32'h0000_0000;
    next_func_setup  = func_setup;
    next_pulse_setup = pulse_setup;
    next_input_func  = input_func;
    next_lock_speed  = lock_speed;
    next_overrate    = overrate;
    if (next_ack && !wb_we_i) begin
      case (adr_word)
        FUNC_SETUP_OFF:  next_dat = {16'h0000, func_setup};
        PULSE_SETUP_OFF: next_dat = {16'h0000, pulse_setup};
        INPUT_FUNC_OFF:  next_dat = {28'h0000000, input_func};
        LOCK_SPEED_OFF:  next_dat = {16'h0000, lock_speed};
        ERR_COUNT_OFF:   next_dat = {{(32-ERR_W){error_count_o[ERR_W-1]}}, error_count_o};
        STATUS_OFF:      next_dat = {24'h000000, status};
        default:         next_dat = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      case (adr_word)
        FUNC_SETUP_OFF:  next_func_setup = merge16(func_setup, wb_dat_i, wb_sel_i);
        PULSE_SETUP_OFF: next_pulse_setup = merge16(pulse_setup, wb_dat_i, wb_sel_i);
        LOCK_SPEED_OFF:  next_lock_speed = merge16(lock_speed, wb_dat_i, wb_sel_i);
        INPUT_FUNC_OFF: begin
          if (wb_sel_i[0]) begin
            next_input_func = wb_dat_i[3:0];
          end
        end
        STATUS_OFF: begin
          if (wb_sel_i[0] && wb_dat_i[ST_OVERRATE]) begin
            next_overrate = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A violation in the clearing cycle must survive the clear.
    if (overrate_hit) begin // see RQ2
      next_overrate = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_setup  <= FUNC_SETUP_RST;
      pulse_setup <= PULSE_SETUP_RST;
      input_func  <= INPUT_FUNC_RST;
      lock_speed  <= LOCK_SPEED_RST;
      overrate    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      wb_ack_o    <= 1'b0;
    end else if (ce_i) begin
      func_setup  <= next_func_setup;
      pulse_setup <= next_pulse_setup;
      input_func  <= next_input_func;
      lock_speed  <= next_lock_speed;
      overrate    <= next_overrate;
      wb_dat_o    <= next_dat;
      wb_ack_o    <= next_ack;
    end
  end

  // ==========================================================================
  // Control inputs
  logic       next_enable;
  logic       next_gain;
  logic       next_alt;
  logic       next_lock;
  logic       next_inhibit;
  logic [1:0] next_speed_sel;
  logic       next_int_rev;
  logic       next_fwd_inh;

  always_comb begin
    next_enable    = run_auto | run_command_i; // see RQ5 see RQ6
    next_gain      = ((input_func <= IFN_GAIN_LAST) & multifunction_input_i) // see RQ7
                   | ((input_func >= IFN_SPEED_FIRST) & (input_func <= IFN_SPEED_GAIN_LAST)
                      & multifunction_input_i & ~speed_chosen);
    next_alt       = (input_func >= IFN_MODE_FIRST) & (input_func <= IFN_MODE_LAST)
                   & multifunction_input_i; // see RQ8
    next_lock      = (input_func == IFN_LOCK) & multifunction_input_i
                   & (motor_speed_i <= lock_speed); // see RQ9
    next_inhibit   = (input_func == IFN_INHIBIT) & multifunction_input_i; // see RQ10
    next_speed_sel = speed_mode ? {speed_select_two_i, speed_select_one_i} : 2'b00; // see RQ14
    next_int_rev   = speed_mode & speed_chosen & multifunction_input_i; // see RQ11
    next_fwd_inh   = ~fwd_ignore & ~forward_prohibit_input_i; // see RQ12 see RQ13
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_enable_o     <= 1'b0;
      gain_reduce_o      <= 1'b0;
      alt_mode_o         <= 1'b0;
      position_lock_o    <= 1'b0;
      pulse_inhibit_o    <= 1'b0;
      internal_speed_o   <= 2'b00;
      internal_reverse_o <= 1'b0;
      forward_inhibit_o  <= 1'b0;
    end else if (ce_i) begin
      servo_enable_o     <= next_enable;
      gain_reduce_o      <= next_gain;
      alt_mode_o         <= next_alt;
      position_lock_o    <= next_lock;
      pulse_inhibit_o    <= next_inhibit;
      internal_speed_o   <= next_speed_sel;
      internal_reverse_o <= next_int_rev;
      forward_inhibit_o  <= next_fwd_inh;
    end
  end

  // ==========================================================================
  // Position error counter and rate check
  localparam logic [ERR_W-1:0] ERR_ONE = {{(ERR_W-1){1'b0}}, 1'b1};
  localparam logic [ERR_W-1:0] ERR_NEG = {ERR_W{1'b1}};

  logic [GAP_W-1:0] gap;
  logic [GAP_W-1:0] next_gap;
  logic [ERR_W-1:0] next_err;
  logic [ERR_W-1:0] cmd_term;
  logic [ERR_W-1:0] fb_term;

  // The gap is measured on every decoded pulse, inhibited or not.
  assign overrate_hit = cmd_step & (gap < MIN_GAP); // see RQ2

  always_comb begin
    cmd_term = '0;
    fb_term  = '0;
    if (cmd_step && !pulse_inhibit_o) begin // see RQ10
      cmd_term = cmd_rev ? ERR_NEG : ERR_ONE; // see RQ15
    end
    if (feedback_step_i) begin
      fb_term = feedback_reverse_i ? ERR_NEG : ERR_ONE; // see RQ15
    end
    next_err = ERR_W'(error_count_o + cmd_term - fb_term);
    if (clear_now) begin
      next_err = '0; // see RQ3
    end
    if (cmd_step) begin
      next_gap = {{(GAP_W-1){1'b0}}, 1'b1};
    end else if (gap < MIN_GAP) begin
      next_gap = GAP_W'(gap + 1'b1);
    end else begin
      next_gap = gap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_count_o <= '0;
      gap           <= MIN_GAP;
    end else if (ce_i) begin
      error_count_o <= next_err;
      gap           <= next_gap;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence fwd_only_s;
    ce_i && cmd_step && !cmd_rev && !pulse_inhibit_o && !feedback_step_i && !clear_now;
  endsequence

  sequence fast_pair_s;
    (ce_i && cmd_step) ##1 (ce_i && !cmd_step) [*3] ##1 (ce_i && cmd_step);
  endsequence

  sequence held_clear_s;
    ce_i && clr_edge_mode && error_counter_clear_input_i && !clr_rise;
  endsequence

  count_step_a: assert property (fwd_only_s |=> error_count_o == ERR_W'($past(error_count_o) + 1'b1)) // see RQ15
    else $error("forward command step not counted");

  rate_flag_a: assert property (fast_pair_s |=> overrate [*2]) // see RQ2
    else $error("too fast pulse pair not flagged");

  clear_level_a: assert property (ce_i && !clr_edge_mode && error_counter_clear_input_i // see RQ3
    |=> error_count_o == '0)
    else $error("level clear did not zero the counter");

  clear_edge_a: assert property (held_clear_s ##0 (cmd_step && !pulse_inhibit_o // see RQ4
    && !feedback_step_i) |=> error_count_o != $past(error_count_o))
    else $error("held clear blocked counting in edge mode");

  run_enable_a: assert property (ce_i && !run_auto |=> servo_enable_o == $past(run_command_i)) // see RQ5
    else $error("servo enable does not follow run input");

  auto_enable_a: assert property (ce_i && run_auto |=> servo_enable_o) // see RQ6
    else $error("auto run did not hold servo enabled");

  gain_reduce_a: assert property (ce_i && input_func <= IFN_GAIN_LAST // see RQ7
    |=> gain_reduce_o == $past(multifunction_input_i))
    else $error("gain reduction does not follow input");

  alt_mode_a: assert property (ce_i && input_func >= IFN_MODE_FIRST && input_func <= IFN_MODE_LAST // see RQ8
    |=> alt_mode_o == $past(multifunction_input_i) && !gain_reduce_o)
    else $error("control mode switch wrong");

  lock_speed_a: assert property (ce_i && input_func == IFN_LOCK && multifunction_input_i // see RQ9
    |=> position_lock_o == $past(motor_speed_i <= lock_speed))
    else $error("position lock speed gate wrong");

  inhibit_hold_a: assert property (ce_i && pulse_inhibit_o && cmd_step && !feedback_step_i // see RQ10
    && !clear_now |=> $stable(error_count_o))
    else $error("inhibited pulse reached the counter");

  int_dir_a: assert property (ce_i && speed_mode && speed_chosen // see RQ11
    |=> internal_reverse_o == $past(multifunction_input_i))
    else $error("internal speed direction wrong");

  fwd_prohibit_a: assert property (ce_i && !fwd_ignore && !forward_prohibit_input_i // see RQ12
    |=> forward_inhibit_o)
    else $error("forward prohibit not applied");

  prohibit_off_a: assert property (ce_i && fwd_ignore |=> !forward_inhibit_o) // see RQ13
    else $error("ignored forward prohibit still inhibits");

  speed_sel_a: assert property (ce_i |=> internal_speed_o == // see RQ14
    ($past(speed_mode) ? $past({speed_select_two_i, speed_select_one_i}) : 2'b00))
    else $error("internal speed selection wrong");

endmodule // servo_command_input_decoder

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model
  import servo_pkg::*;
(
  input  wire logic clk_i,
  output logic      pulse_a_o,
  output logic      pulse_b_o
);
  // ==========================================================================
  // Command pulse source
  // The quadrature phase is kept across calls so that a later run resumes cleanly.
  logic [1:0] phase = 2'h0;

  initial begin
    pulse_a_o = 1'b0;
    pulse_b_o = 1'b0;
  end

  // A gap below the legal spacing is used only when a test asks for it.
  task automatic send(input pulse_fmt_t fmt, input logic rev, input int count, input int gap);
    if (fmt == FMT_PULSE_DIR) begin
      @(posedge clk_i);
      pulse_b_o <= rev;
    end
    for (int i = 0; i < count; i++) begin
      @(posedge clk_i);
      if (fmt == FMT_QUAD) begin
        phase = rev ? phase - 2'h1 : phase + 2'h1;
        pulse_a_o <= phase[0] ^ phase[1];
        pulse_b_o <= phase[1];
      end else if (fmt == FMT_TRAINS && !rev) begin
        pulse_b_o <= 1'b1;
      end else begin
        pulse_a_o <= 1'b1;
      end
      repeat (2) @(posedge clk_i);
      if (fmt != FMT_QUAD) begin
        pulse_a_o <= 1'b0;
        if (fmt == FMT_TRAINS) pulse_b_o <= 1'b0;
      end
      repeat (gap - 3) @(posedge clk_i);
    end
  endtask
endmodule  // host_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import servo_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce    = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] dout, rdat;
  logic        ack, pa, pb, en, gain, alt, lock, inh, irev, finh;
  logic        ecc = 1'b0, run = 1'b0, mf = 1'b0, fp = 1'b1, s1 = 1'b0, s2 = 1'b0;
  logic        fb  = 1'b0, fbr = 1'b0;
  logic [15:0] spd = 16'h0000;
  logic [1:0]  isp;
  logic [23:0] cnt;
  int          bad_count = 0, tests_run = 0, exp = 0;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  host_model i_host (.clk_i(clk_i), .pulse_a_o(pa), .pulse_b_o(pb));

  servo_command_input_decoder #(.ERR_W(24)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .pulse_a_i(pa), .pulse_b_i(pb), .error_counter_clear_input_i(ecc),
    .run_command_i(run), .multifunction_input_i(mf), .forward_prohibit_input_i(fp),
    .speed_select_one_i(s1), .speed_select_two_i(s2), .motor_speed_i(spd),
    .feedback_step_i(fb), .feedback_reverse_i(fbr), .servo_enable_o(en),
    .gain_reduce_o(gain), .alt_mode_o(alt), .position_lock_o(lock),
    .pulse_inhibit_o(inh), .internal_speed_o(isp), .internal_reverse_o(irev),
    .forward_inhibit_o(finh), .error_count_o(cnt));

  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask

  // Only the watchdog ends a wait on a slave that never answers.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic chk_cnt();
    repeat (4) @(posedge clk_i);
    check("error_count", {8'h00, cnt}, {8'h00, exp[23:0]});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      check("reset_read", rdat, (i == 3) ? {16'h0000, LOCK_SPEED_RST} : 32'h0);
    end
    for (int k = 0; k < 16; k++) begin
      wb(1'b1, FUNC_SETUP_OFF, {29'h0, k[1], 1'b0, k[0]});
      @(posedge clk_i);
      run <= k[2];
      fp  <= k[3];
      repeat (3) @(posedge clk_i);
      check("servo_enable", en, k[0] | k[2]);
      check("forward_inhibit", finh, !k[3] && !k[1]);
    end
    for (int f = 0; f < 12; f++) begin
      wb(1'b1, INPUT_FUNC_OFF, 32'(f));
      for (int k = 0; k < 8; k++) begin
        @(posedge clk_i);
        mf  <= k[0];
        s1  <= k[1];
        s2  <= k[2];
        spd <= (k[2:1] == 2'h3) ? 16'h0011 : 16'h0010;
        repeat (3) @(posedge clk_i);
        check("gain", gain, k[0] && (f <= 1 || (f >= 3 && f <= 5 && k[2:1] == 0)));
        check("alt_mode", alt, k[0] && f >= 7 && f <= 9);
        check("lock", lock, k[0] && f == 10 && k[2:1] != 2'h3);
        check("inhibit", inh, k[0] && f == 11);
        check("int_speed", isp, (f >= 3 && f <= 6) ? k[2:1] : 0);
        check("int_reverse", irev, k[0] && f >= 3 && f <= 6 && k[2:1] != 0);
      end
    end
    // A low clock enable must hold the inhibit although its input has dropped.
    ce <= 1'b0;
    mf <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("ce_freeze", inh, 1'b1);
    ce <= 1'b1;
    // Function 11 is still selected: a held input must swallow command pulses.
    @(posedge clk_i);
    mf <= 1'b1;
    i_host.send(FMT_PULSE_DIR, 1'b0, 1, MIN_GAP_CYC);
    chk_cnt();
    mf <= 1'b0;
    wb(1'b1, PULSE_SETUP_OFF, 32'h0000_0010);
    i_host.send(FMT_QUAD, 1'b0, 6, MIN_GAP_CYC);
    exp += 6;
    chk_cnt();
    i_host.send(FMT_QUAD, 1'b1, 2, MIN_GAP_CYC);
    exp -= 2;
    chk_cnt();
    wb(1'b1, PULSE_SETUP_OFF, 32'h0000_0008);
    i_host.send(FMT_TRAINS, 1'b0, 3, MIN_GAP_CYC);
    i_host.send(FMT_TRAINS, 1'b1, 5, MIN_GAP_CYC);
    exp -= 2;
    chk_cnt();
    // Format code 7 is unassigned and must fall back to pulse plus sign.
    wb(1'b1, PULSE_SETUP_OFF, 32'h0000_0038);
    i_host.send(FMT_PULSE_DIR, 1'b1, 4, MIN_GAP_CYC);
    i_host.send(FMT_PULSE_DIR, 1'b0, 1, MIN_GAP_CYC);
    exp -= 3;
    chk_cnt();
    @(posedge clk_i);
    fb <= 1'b1;
    @(posedge clk_i);
    fb <= 1'b0;
    exp -= 1;
    chk_cnt();
    wb(1'b0, ERR_COUNT_OFF, 32'h0);
    check("err_reg", rdat, 32'(exp));
    wb(1'b0, STATUS_OFF, 32'h0);
    check("overrate", rdat[7], 1'b0);
    ecc <= 1'b1;
    i_host.send(FMT_PULSE_DIR, 1'b0, 1, MIN_GAP_CYC);
    exp = 0;
    chk_cnt();
    ecc <= 1'b0;
    wb(1'b1, PULSE_SETUP_OFF, 32'h0000_0400);
    i_host.send(FMT_PULSE_DIR, 1'b0, 2, MIN_GAP_CYC);
    ecc <= 1'b1;
    i_host.send(FMT_PULSE_DIR, 1'b0, 1, MIN_GAP_CYC);
    exp = 1;
    chk_cnt();
    ecc <= 1'b0;
    i_host.send(FMT_PULSE_DIR, 1'b0, 2, 4);
    wb(1'b0, STATUS_OFF, 32'h0);
    check("overrate", rdat[7], 1'b1);
    wb(1'b1, STATUS_OFF, 32'h0000_0080);
    wb(1'b0, STATUS_OFF, 32'h0);
    check("overrate_clr", rdat[7], 1'b0);
    give_verdict();
  end
endmodule  // tb_top
